// >>> rtl/ccc_charge_ctrl.v
/*
 * Charge cycle controller: phase sequencing, termination, recharge,
 * safety, pre-charge and top-off timers, temperature zone limits,
 * indicator pin, host event pulse and an AXI4-Lite register slave.
 * Assumes analog comparators and regulators outside, on their own
 * timing, and one 20 MHz clock with an active-low async reset.
 */
`timescale 1ns/1ps
`include "ccc_charge_regs.vh"

module ccc_charge_ctrl #(
    parameter TICK_CYCLES = `CCC_CLK_HZ
) (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // AXI4-Lite write
    input wire [4:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // AXI4-Lite read
    input wire [4:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Pins and analog flags, asynchronous
    input wire permitN,
    input wire converterOn,
    input wire belowShort,
    input wire belowLow,
    input wire belowRecharge,
    input wire currentBelowTerm,
    input wire inputRegActive,
    input wire thermalRegActive,
    input wire voltRegActive,
    input wire tsInWindow,
    input wire tsWarm,
    input wire tsCool,
    input wire supplementReq,
    // Analog targets and power switch
    output reg [13:0] targetVoltage,
    output reg [11:0] targetCurrent,
    output reg [1:0] rechargeSelect,
    output reg batterySwitchOn,
    // Indicator pin and host event
    output reg statOut,
    output reg statOe,
    output reg intPulse
);
    localparam S_IDLE = 3'd0;
    localparam S_TRICKLE = 3'd1;
    localparam S_PRE = 3'd2;
    localparam S_FAST = 3'd3;
    localparam S_TAPER = 3'd4;
    localparam S_TOPOFF = 3'd5;
    localparam S_DONE = 3'd6;
    localparam S_FAULT = 3'd7;
    localparam NSYNC = 13;

    // Three-stage synchronisers, a change counts when stages two and three agree
    wire [NSYNC-1:0] rawIn = {supplementReq, tsCool, tsWarm, tsInWindow, voltRegActive, thermalRegActive,
        inputRegActive, currentBelowTerm, belowRecharge, belowLow, belowShort, converterOn, permitN};
    wire [NSYNC-1:0] fil;
    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : gSync
            reg s1_reg, s2_reg, s3_reg, f_reg;
            always @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    f_reg <= 1'b0;
                end else begin
                    s1_reg <= rawIn[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) f_reg <= s3_reg;
                end
            end
            assign fil[g] = f_reg;
        end
    endgenerate
    wire pPermitN = fil[0];
    wire pConv = fil[1];
    wire pShort = fil[2];
    wire pLow = fil[3];
    wire pRechg = fil[4];
    wire pCurTerm = fil[5];
    wire regActive = fil[6] | fil[7];
    wire pVreg = fil[8];
    wire pWin = fil[9];
    wire pWarm = fil[10];
    wire pCool = fil[11];
    wire pSupp = fil[12];

    // Registers
    reg [15:0] ctrl_reg;
    reg [13:0] vset_reg;
    reg [11:0] iset_reg;
    reg [15:0] tmr_reg;
    reg [2:0] state_reg;
    reg timerFault_reg;

    // AXI write channel: address and data taken in either order
    reg awHeld_reg, wHeld_reg;
    reg [4:0] awAddr_reg;
    reg [31:0] wData_reg;
    reg [3:0] wStrb_reg;
    assign awready = !awHeld_reg && !bvalid;
    assign wready = !wHeld_reg && !bvalid;
    assign arready = !rvalid;
    wire [4:0] wa = awHeld_reg ? awAddr_reg : awaddr;
    wire [31:0] wd = wHeld_reg ? wData_reg : wdata;
    wire [3:0] ws = wHeld_reg ? wStrb_reg : wstrb;
    wire haveAw = awHeld_reg || (awvalid && awready);
    wire haveW = wHeld_reg || (wvalid && wready);
    wire doWrite = haveAw && haveW;
    wire [15:0] bmask = {{8{ws[1]}}, {8{ws[0]}}};
    wire wrMapped = (wa[4] == 1'b0) && (wa[1:0] == 2'b00);
    wire wrCtrl = doWrite && wrMapped && (wa[3:0] == `CCC_OFF_CTRL);
    wire wrVset = doWrite && wrMapped && (wa[3:0] == `CCC_OFF_VSET);
    wire wrIset = doWrite && wrMapped && (wa[3:0] == `CCC_OFF_ISET);
    wire wrTmr = doWrite && wrMapped && (wa[3:0] == `CCC_OFF_TMR);
    wire restore = wrCtrl && bmask[`CCC_CTRL_RESTORE] && wd[`CCC_CTRL_RESTORE];
    wire [15:0] ctrlMerged = (ctrl_reg & ~bmask) | (wd[15:0] & bmask);
    wire [15:0] vsetMerged = ({2'b00, vset_reg} & ~bmask) | (wd[15:0] & bmask);
    wire [15:0] isetMerged = ({4'h0, iset_reg} & ~bmask) | (wd[15:0] & bmask);
    wire [15:0] tmrMerged = (tmr_reg & ~bmask) | (wd[15:0] & bmask);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 5'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
        end else begin
            if (awvalid && awready) awAddr_reg <= awaddr;
            if (wvalid && wready) begin
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
            if (doWrite) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wrCtrl || wrVset || wrIset || wrTmr) ? 2'b00 : 2'b10;
            end else begin
                awHeld_reg <= haveAw;
                wHeld_reg <= haveW;
                if (bvalid && bready) bvalid <= 1'b0;
            end
        end
    end

    // Settings; restore reloads defaults, which also disables top-off
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= `CCC_CTRL_RST;
            vset_reg <= `CCC_VSET_RST;
            iset_reg <= `CCC_ISET_RST;
            tmr_reg <= `CCC_TMR_RST;
        end else if (restore) begin
            ctrl_reg <= `CCC_CTRL_RST;
            vset_reg <= `CCC_VSET_RST;
            iset_reg <= `CCC_ISET_RST;
            tmr_reg <= `CCC_TMR_RST;
        end else begin
            if (wrCtrl) ctrl_reg <= ctrlMerged;
            if (wrVset) vset_reg <= vsetMerged[13:0];
            if (wrIset) iset_reg <= isetMerged[11:0];
            if (wrTmr) tmr_reg <= tmrMerged;
        end
    end

    // Read channel; unmapped offsets answer SLVERR with zero data
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= 2'b00;
            case (araddr)
                {1'b0, `CCC_OFF_CTRL}: rdata <= {16'h0000, ctrl_reg};
                {1'b0, `CCC_OFF_VSET}: rdata <= {18'h0_0000, vset_reg};
                {1'b0, `CCC_OFF_ISET}: rdata <= {20'h0_0000, iset_reg};
                {1'b0, `CCC_OFF_TMR}: rdata <= {16'h0000, tmr_reg};
                `CCC_ADDR_STAT: rdata <= {26'h000_0000, batterySwitchOn, statOut, timerFault_reg,
                    (state_reg == S_FAULT) ? S_IDLE : state_reg};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= 2'b10;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // Control decodes
    wire chgEnable = ctrl_reg[`CCC_CTRL_EN];
    wire enabled = chgEnable && !pPermitN;
    wire warmSusp = pWarm && (ctrl_reg[`CCC_CTRL_WARM_V] == 2'd3);
    wire coolSusp = pCool && (ctrl_reg[`CCC_CTRL_COOL_I] == 2'd3);
    wire suspend = !pWin || warmSusp || coolSusp || pSupp;
    wire startOk = pConv && enabled && (iset_reg != 12'd0) && pWin && !timerFault_reg;
    wire termOk = pCurTerm && !pRechg && !regActive && ctrl_reg[`CCC_CTRL_TERM]
        && !pWarm && !pCool && !suspend;
    wire charging = (state_reg >= S_TRICKLE) && (state_reg <= S_TOPOFF);
    wire halfRate = ctrl_reg[`CCC_CTRL_HALF_EN] && regActive;

    // One-second tick; half rate passes every second tick
    reg [24:0] pre_reg;
    reg halfPhase_reg, blink_reg, enabledPrev_reg, lowPrev_reg;
    wire tick = (pre_reg == TICK_CYCLES - 1);
    wire tickEff = tick && (!halfRate || halfPhase_reg);
    wire enRise = enabled && !enabledPrev_reg;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pre_reg <= 25'd0;
            halfPhase_reg <= 1'b0;
            blink_reg <= 1'b0;
            enabledPrev_reg <= 1'b0;
            lowPrev_reg <= 1'b0;
        end else begin
            pre_reg <= tick ? 25'd0 : pre_reg + 25'd1;
            if (tick) halfPhase_reg <= !halfPhase_reg;
            if (tick) blink_reg <= !blink_reg;
            enabledPrev_reg <= enabled;
            lowPrev_reg <= pLow;
        end
    end

    // Safety and pre-charge timer in seconds
    reg [16:0] safeCnt_reg;
    wire [16:0] hours = pLow ? {12'd0, `CCC_PRECHG_HOURS} : {12'd0, tmr_reg[`CCC_TMR_HOURS]};
    wire [16:0] safeLimit = hours * `CCC_SEC_PER_HOUR;
    wire safeRun = ctrl_reg[`CCC_CTRL_TMR_EN] && charging && (state_reg != S_TOPOFF) && !suspend;
    wire safeExpire = safeRun && (safeCnt_reg >= safeLimit);
    always @(posedge clock or negedge rstn) begin
        if (!rstn) safeCnt_reg <= 17'd0;
        else if (state_reg == S_IDLE || pLow != lowPrev_reg) safeCnt_reg <= 17'd0;
        else if (safeRun && tickEff) safeCnt_reg <= safeCnt_reg + 17'd1;
    end

    // Top-off timer: latched length, cleared on enable, termination and restore
    reg [7:0] topLen_reg;
    reg [13:0] topCnt_reg;
    reg doneStat_reg;
    wire termDetect = (state_reg == S_FAST || state_reg == S_TAPER) && termOk;
    wire [13:0] topLimit = {6'd0, topLen_reg} * `CCC_SEC_PER_MIN;
    wire topExpire = (state_reg == S_TOPOFF) && (topCnt_reg >= topLimit);
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            topLen_reg <= 8'd0;
            topCnt_reg <= 14'd0;
            doneStat_reg <= 1'b0;
        end else begin
            doneStat_reg <= termDetect ? 1'b1 : (state_reg == S_IDLE ? 1'b0 : doneStat_reg);
            if (termDetect) topLen_reg <= tmr_reg[`CCC_TMR_TOPOFF];
            else if (restore) topLen_reg <= 8'd0;
            if (enRise || (termDetect && !doneStat_reg) || restore) topCnt_reg <= 14'd0;
            else if (state_reg == S_TOPOFF && !suspend && tickEff) topCnt_reg <= topCnt_reg + 14'd1;
        end
    end

    // Phase sequencer
    reg [2:0] state_next;
    reg event_next;
    always @* begin
        state_next = state_reg;
        event_next = 1'b0;
        case (state_reg)
            S_IDLE: begin
                if (startOk) begin
                    if (pShort) state_next = S_TRICKLE;
                    else if (pLow) state_next = S_PRE;
                    else state_next = S_FAST;
                end
            end
            S_TRICKLE: if (!pShort) state_next = S_PRE;
            S_PRE: if (!pLow) state_next = S_FAST;
            S_FAST: if (pVreg) state_next = S_TAPER;
            S_TAPER: state_next = S_TAPER;
            S_TOPOFF: begin
                if (topExpire) begin
                    state_next = S_DONE;
                    event_next = 1'b1;
                end
            end
            S_DONE: if (pRechg) state_next = S_IDLE;
            S_FAULT: state_next = S_FAULT;
            default: state_next = S_IDLE;
        endcase
        if (termDetect) begin
            state_next = (tmr_reg[`CCC_TMR_TOPOFF] != 8'd0) ? S_TOPOFF : S_DONE;
            event_next = 1'b1;
        end
        if (safeExpire) state_next = S_FAULT;
        if (!enabled || !pConv || (state_reg == S_FAULT && enRise)) state_next = S_IDLE;
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= S_IDLE;
            timerFault_reg <= 1'b0;
            intPulse <= 1'b0;
        end else begin
            state_reg <= state_next;
            // A new expiry beats a clearing toggle in the same cycle
            if (safeExpire) timerFault_reg <= 1'b1;
            else if (enRise) timerFault_reg <= 1'b0;
            intPulse <= (event_next && !ctrl_reg[`CCC_CTRL_MASK]) || safeExpire;
        end
    end

    // Regulation targets per phase and temperature zone
    wire [13:0] isetWide = {2'b00, iset_reg};
    wire [13:0] i40 = (isetWide * 14'd2) / 14'd5;
    wire [13:0] i20 = isetWide / 14'd5;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            targetVoltage <= `CCC_VSET_RST;
            targetCurrent <= 12'd0;
            rechargeSelect <= 2'b00;
        end else begin
            rechargeSelect <= ctrl_reg[`CCC_CTRL_RECHG];
            targetVoltage <= vset_reg;
            if (pWarm && ctrl_reg[`CCC_CTRL_WARM_V] == 2'd1) targetVoltage <= `CCC_WARM_V1_MV;
            if (pWarm && ctrl_reg[`CCC_CTRL_WARM_V] == 2'd2) targetVoltage <= `CCC_WARM_V2_MV;
            if (!charging || suspend) targetCurrent <= 12'd0;
            else if (state_reg == S_TRICKLE) targetCurrent <= `CCC_TRICKLE_MA;
            else if (state_reg == S_PRE) targetCurrent <= `CCC_PRECHG_MA;
            else if (pWarm && ctrl_reg[`CCC_CTRL_WARM_I]) targetCurrent <= i40[11:0];
            else if (pCool && ctrl_reg[`CCC_CTRL_COOL_I] == 2'd1) targetCurrent <= i40[11:0];
            else if (pCool && ctrl_reg[`CCC_CTRL_COOL_I] == 2'd2) targetCurrent <= i20[11:0];
            else targetCurrent <= iset_reg;
        end
    end

    // Indicator pin and battery switch; done state releases the battery unless supplement is requested
    wire chgFault = timerFault_reg || (enabled && !pWin);
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            statOut <= 1'b1;
            statOe <= 1'b0;
            batterySwitchOn <= 1'b1;
        end else begin
            statOe <= !ctrl_reg[`CCC_CTRL_IND_DIS];
            if (chgFault) statOut <= blink_reg;
            else statOut <= !charging || (state_next == S_TOPOFF);
            batterySwitchOn <= (state_reg != S_DONE) || pSupp;
        end
    end
endmodule // ccc_charge_ctrl

// >>> rtl/ccc_charge_regs.vh
/*
 * Register map, field positions, reset values and timing constants
 * for the charge cycle controller. Definitions only.
 */
`ifndef CCC_CHARGE_REGS_VH
`define CCC_CHARGE_REGS_VH

// Byte offsets on the register bus
`define CCC_OFF_CTRL 4'h0
`define CCC_OFF_VSET 4'h4
`define CCC_OFF_ISET 4'h8
`define CCC_OFF_TMR 4'hC
`define CCC_ADDR_STAT 5'h10

// Control register fields
`define CCC_CTRL_EN 0
`define CCC_CTRL_TERM 1
`define CCC_CTRL_IND_DIS 2
`define CCC_CTRL_MASK 3
`define CCC_CTRL_TMR_EN 4
`define CCC_CTRL_HALF_EN 5
`define CCC_CTRL_RESTORE 6
`define CCC_CTRL_RECHG 9:8
`define CCC_CTRL_WARM_V 11:10
`define CCC_CTRL_WARM_I 12
`define CCC_CTRL_COOL_I 14:13

// Timer register fields
`define CCC_TMR_HOURS 4:0
`define CCC_TMR_TOPOFF 15:8

// Reset values
`define CCC_CTRL_RST 16'h0033
`define CCC_VSET_RST 14'd8400
`define CCC_ISET_RST 12'd1500
`define CCC_TMR_RST 16'h000C

// Fixed currents and warm voltages, mA and mV
`define CCC_TRICKLE_MA 12'd100
`define CCC_PRECHG_MA 12'd150
`define CCC_WARM_V1_MV 14'd8000
`define CCC_WARM_V2_MV 14'd8300

// Timing
`define CCC_CLK_HZ 20000000
`define CCC_PRECHG_HOURS 5'd2
`define CCC_SEC_PER_HOUR 17'd3600
`define CCC_SEC_PER_MIN 14'd60
`define CCC_BLINK_TICKS 1

`endif

// >>> sim/ccc_batt_model.sv
/*
 * Two-cell pack with thermistor, seen by the charge controller as clean
 * comparator flags. Assumes the bench sets pack voltage and temperature zone.
 */
`timescale 1ns/1ps
module ccc_batt_model #(
    parameter SHORT_MV = 5000,
    parameter LOW_MV = 6000
) (
    // Pack state from the bench
    input wire [13:0] battMv,
    input wire [1:0] zone,
    // Charger targets
    input wire [13:0] targetVoltage,
    input wire [1:0] rechargeSelect,
    // Comparator and zone flags
    output wire belowShort,
    output wire belowLow,
    output wire belowRecharge,
    output wire currentBelowTerm,
    output wire voltRegActive,
    output wire tsInWindow,
    output wire tsWarm,
    output wire tsCool
);
    // Level comparisons, already settled levels
    assign belowShort = battMv < SHORT_MV;
    assign belowLow = battMv < LOW_MV;
    // Recharge level 100 mV a step below target
    assign belowRecharge = battMv < targetVoltage - 14'h0064 * ({12'h000, rechargeSelect} + 14'h0001);
    // Full pack: voltage loop holds, current has tapered off
    assign voltRegActive = battMv >= targetVoltage;
    assign currentBelowTerm = battMv >= targetVoltage;
    // Zone 0 normal, 1 warm, 2 cool, 3 out of window
    assign tsInWindow = zone != 2'h3;
    assign tsWarm = zone == 2'h1;
    assign tsCool = zone == 2'h2;
endmodule // ccc_batt_model

// >>> sim/ccc_charge_ctrl_chk.sv
/*
 * Port-level checker for the charge cycle controller.
 * Assumes flags settle within eight clocks through the input filters.
 */
`timescale 1ns/1ps
module ccc_charge_ctrl_chk (
    // Clock and reset
    input wire clock,
    input wire rstn,
    // Register bus
    input wire [4:0] awaddr,
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire [1:0] bresp,
    input wire bvalid,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    // Pins and flags
    input wire permitN,
    input wire converterOn,
    input wire tsInWindow,
    input wire supplementReq,
    input wire belowShort,
    // Outputs under watch
    input wire [11:0] targetCurrent,
    input wire batterySwitchOn,
    input wire statOut,
    input wire statOe,
    input wire intPulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Bus answers; writes at the status offset and above are unmapped
    wr_resp_a: assert property (awvalid && awready && wvalid && wready
        |=> bvalid && bresp == (($past(awaddr) >= 5'h10) ? 2'b10 : 2'b00)) else $error("write answer wrong");
    rd_resp_a: assert property (arvalid && arready |=> rvalid) else $error("read answer missing");
    wr_busy_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
    rd_busy_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
    // Filters take a few clocks, so eight samples leave margin
    permit_stop_a: assert property (permitN [*8] |=> targetCurrent == 12'h000)
        else $error("charging without permit");
    conv_stop_a: assert property (!converterOn [*8] |=> targetCurrent == 12'h000)
        else $error("charging with converter off");
    window_stop_a: assert property (!tsInWindow [*8] |=> targetCurrent == 12'h000)
        else $error("charging outside thermistor window");
    supp_switch_a: assert property (supplementReq [*8] |=> batterySwitchOn && targetCurrent == 12'h000)
        else $error("supplement without switch");
    int_single_a: assert property (intPulse |=> !intPulse)
        else $error("event pulse too long");
    trickle_cur_a: assert property (belowShort [*8] ##0 targetCurrent != 12'h000 |-> targetCurrent == 12'h064)
        else $error("trickle current wrong");
    charge_ind_a: assert property ($rose(targetCurrent != 12'h000) |=> !statOut || !statOe)
        else $error("indicator not low while charging");
    done_ind_a: assert property (!batterySwitchOn |-> statOut || !statOe)
        else $error("indicator not high when done");
endmodule // ccc_charge_ctrl_chk

bind ccc_charge_ctrl ccc_charge_ctrl_chk chk_i (.clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .permitN(permitN), .converterOn(converterOn), .tsInWindow(tsInWindow),
    .supplementReq(supplementReq), .belowShort(belowShort), .targetCurrent(targetCurrent),
    .batterySwitchOn(batterySwitchOn), .statOut(statOut), .statOe(statOe), .intPulse(intPulse));

// >>> sim/tb_top.sv
/*
 * Self-checking bench: register bus tasks and charge cycle sequences.
 * Assumes the timer base is shortened to four clocks a tick.
 */
`timescale 1ns/1ps
`include "ccc_charge_regs.vh"
module tb_top;
    logic clock, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic permitN, converterOn, inputRegActive, supplementReq;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, d;
    logic [3:0] wstrb;
    logic [13:0] battMv;
    logic [1:0] zone;
    wire awready, wready, bvalid, arready, rvalid, batterySwitchOn, statOut, statOe, intPulse;
    wire belowShort, belowLow, belowRecharge, currentBelowTerm, voltRegActive, tsInWindow, tsWarm, tsCool;
    wire [1:0] bresp, rresp, rechargeSelect;
    wire [31:0] rdata;
    wire [13:0] targetVoltage;
    wire [11:0] targetCurrent;
    int n_fail, samples_checked, nInt, nI, i;
    logic [13:0] bm [3] = '{14'h0FA0, 14'h157C, 14'h1B58};
    logic [11:0] bc [3] = '{12'h064, 12'h096, 12'h5DC};
    logic [15:0] zc [5] = '{16'h0433, 16'h1033, 16'h4033, 16'h6033, 16'h0033};
    logic [1:0] zz [5] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [13:0] zv [5] = '{14'h1F40, 14'h20D0, 14'h20D0, 14'h20D0, 14'h20D0};
    logic [11:0] zi [5] = '{12'h5DC, 12'h258, 12'h12C, 12'h000, 12'h000};

    ccc_charge_ctrl #(.TICK_CYCLES(4)) dut (.clock(clock), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .permitN(permitN), .converterOn(converterOn),
        .belowShort(belowShort), .belowLow(belowLow), .belowRecharge(belowRecharge),
        .currentBelowTerm(currentBelowTerm), .inputRegActive(inputRegActive), .thermalRegActive(1'b0),
        .voltRegActive(voltRegActive), .tsInWindow(tsInWindow), .tsWarm(tsWarm), .tsCool(tsCool),
        .supplementReq(supplementReq), .targetVoltage(targetVoltage), .targetCurrent(targetCurrent),
        .rechargeSelect(rechargeSelect), .batterySwitchOn(batterySwitchOn), .statOut(statOut), .statOe(statOe),
        .intPulse(intPulse));
    ccc_batt_model model (.battMv(battMv), .zone(zone), .targetVoltage(targetVoltage),
        .rechargeSelect(rechargeSelect), .belowShort(belowShort), .belowLow(belowLow),
        .belowRecharge(belowRecharge), .currentBelowTerm(currentBelowTerm), .voltRegActive(voltRegActive),
        .tsInWindow(tsInWindow), .tsWarm(tsWarm), .tsCool(tsCool));

    // Free-running 20 MHz clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // Event pulse count, sampled like the design sees it
    always @(posedge clock) begin
        if (intPulse === 1'b1) nInt++;
    end

    task automatic chk(input string nm, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Write: address and data offered together, bready held until answer
    task automatic wr(input [4:0] a, input [31:0] v, input [1:0] e);
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {1'b1, e}, {bvalid, bresp});
    endtask
    // Read: waits for the answer without bound, so a missing one runs into the watchdog
    task automatic rd(input [4:0] a);
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = (rvalid === 1'b1) ? rdata : 32'hxxxx_xxxx;
        rready <= 1'b0;
    endtask
    // Poll the phase code until it matches, bounded
    task automatic ph(input [2:0] e);
        int n;
        n = 0;
        do begin
            rd(`CCC_ADDR_STAT);
            n++;
        end while (d[2:0] !== e && n < 120);
        chk("phase", e, d[2:0]);
    endtask
    task automatic wi(input int b);
        int n;
        n = 0;
        while (intPulse !== 1'b1 && n < b) begin
            @(posedge clock);
            n++;
        end
        chk("event pulse", 1, intPulse);
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the longest timer run
    initial begin
        repeat (60000) @(posedge clock);
        n_fail++;
        finish_test();
    end

    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready, inputRegActive, supplementReq, converterOn} = 9'h000;
        {awaddr, araddr, wdata, wstrb, zone, permitN, battMv} = {10'h000, 32'h0000_0000, 4'hF, 2'h0, 1'b1, bm[0]};
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rd(`CCC_OFF_CTRL); chk("ctrl", `CCC_CTRL_RST, d);
        rd(`CCC_OFF_VSET); chk("vset", `CCC_VSET_RST, d);
        rd(`CCC_OFF_ISET); chk("iset", `CCC_ISET_RST, d);
        rd(`CCC_OFF_TMR); chk("tmr", `CCC_TMR_RST, d);
        wr(5'h14, 32'h0000_FFFF, 2'b10);
        rd(5'h14); chk("unmapped", 0, d);
        chk("read resp", 2'b10, rresp);
        ph(3'h0);
        $display("test defaults done");
        converterOn <= 1'b1;
        // Start phase picked from pack voltage
        for (i = 0; i < 3; i++) begin
            battMv <= bm[i];
            cyc(8);
            permitN <= 1'b0;
            ph(i + 1);
            cyc(2);
            chk("start current", bc[i], targetCurrent);
            permitN <= 1'b1;
            ph(3'h0);
        end
        wr(`CCC_OFF_ISET, 32'h0000_0000, 2'b00);
        rd(`CCC_OFF_ISET); chk("iset", 0, d);
        permitN <= 1'b0;
        cyc(20);
        ph(3'h0);
        wr(`CCC_OFF_ISET, 32'h0000_05DC, 2'b00);
        ph(3'h3);
        $display("test start phases done");
        // Regulation holds off termination in taper
        inputRegActive <= 1'b1;
        battMv <= 14'h20D0;
        ph(3'h4);
        cyc(30);
        ph(3'h4);
        nI = nInt;
        inputRegActive <= 1'b0;
        wi(60);
        cyc(3);
        chk("indicator", 1, statOut);
        chk("switch", 0, batterySwitchOn);
        ph(3'h6);
        chk("pulses", nI + 1, nInt);
        supplementReq <= 1'b1;
        cyc(10);
        chk("supplement", 1, batterySwitchOn);
        supplementReq <= 1'b0;
        battMv <= 14'h1F40;
        ph(3'h3);
        $display("test termination done");
        // Top-off of one minute, then masked repeat
        wr(`CCC_OFF_TMR, 32'h0000_010C, 2'b00);
        nI = nInt;
        battMv <= 14'h20D0;
        wi(100);
        ph(3'h5);
        wi(400);
        ph(3'h6);
        chk("pulses", nI + 2, nInt);
        battMv <= 14'h1F40;
        ph(3'h3);
        wr(`CCC_OFF_CTRL, 32'h0000_003B, 2'b00);
        nI = nInt;
        battMv <= 14'h20D0;
        ph(3'h6);
        chk("masked pulses", nI, nInt);
        wr(`CCC_OFF_CTRL, 32'h0000_0033, 2'b00);
        wr(`CCC_OFF_TMR, 32'h0000_000C, 2'b00);
        battMv <= bm[2];
        ph(3'h3);
        $display("test top-off done");
        // Zone limits on voltage and current
        for (i = 0; i < 5; i++) begin
            wr(`CCC_OFF_CTRL, {16'h0000, zc[i]}, 2'b00);
            zone <= zz[i];
            cyc(12);
            chk("zone voltage", zv[i], targetVoltage);
            chk("zone current", zi[i], targetCurrent);
        end
        zone <= 2'h0;
        wr(`CCC_OFF_CTRL, 32'h0000_0033, 2'b00);
        ph(3'h3);
        converterOn <= 1'b0;
        ph(3'h0);
        converterOn <= 1'b1;
        ph(3'h3);
        $display("test zones done");
        wr(`CCC_OFF_CTRL, 32'h0000_0031, 2'b00);
        battMv <= 14'h20D0;
        ph(3'h4);
        cyc(30);
        ph(3'h4);
        battMv <= bm[2];
        // One-hour safety limit after an enable toggle
        wr(`CCC_OFF_TMR, 32'h0000_0001, 2'b00);
        wr(`CCC_OFF_CTRL, 32'h0000_0032, 2'b00);
        wr(`CCC_OFF_CTRL, 32'h0000_0033, 2'b00);
        ph(3'h3);
        wi(16000);
        cyc(3);
        rd(`CCC_ADDR_STAT);
        chk("fault status", 32'h0000_0008, d & 32'h0000_000F);
        chk("fault current", 0, targetCurrent);
        $display("test safety timer done");
        finish_test();
    end
endmodule // tb_top
